// file: logic/pmcd_defines.svh
`ifndef PMCD_DEFINES_SVH
`define PMCD_DEFINES_SVH

// register byte offsets
`define PMCD_ADDR_W        8
`define PMCD_OFF_REG_CTL   8'h00
`define PMCD_OFF_PLL_CONTROL_REG   8'h04
`define PMCD_OFF_PLL_DIV   8'h08
`define PMCD_OFF_SLEEP_CMD 8'h0C
`define PMCD_OFF_SDR_GCTL  8'h10
`define PMCD_OFF_AMEM_GCTL 8'h14
`define PMCD_OFF_STATUS    8'h18

// regulator control fields
`define PMCD_REG_SW_LSB    0
`define PMCD_REG_VLEV_LSB  4
`define PMCD_REG_CKE_BIT   8
`define PMCD_REG_CBUF_BIT  9
`define PMCD_REG_SW_OFF    2'b00
`define PMCD_REG_SW_RST    2'b11
`define PMCD_REG_VLEV_RST  4'hB
`define PMCD_VSTEP_MV      50

// pll control fields
`define PMCD_PLL_DF_BIT    0
`define PMCD_PLL_MSEL_LSB  1
`define PMCD_PLL_BYP_BIT   8
`define PMCD_PLL_MSEL_RST  6'h0A
`define PMCD_LOCK_CYC      8'h10

// pll divider fields
`define PMCD_DIV_SSEL_LSB  0
`define PMCD_DIV_CSEL_LSB  4
`define PMCD_DIV_SSEL_RST  4'h5
`define PMCD_DIV_CSEL_RST  2'b00

// sleep command bits
`define PMCD_CMD_SLEEP_BIT 0
`define PMCD_CMD_DEEP_BIT  1

// hardware reset sequence length
`define PMCD_RST_CYC       8'h20

`endif

// file: logic/pmcd_pkg.sv
package pmcd_pkg;

  // power modes, gray along run -> sleep -> deep sleep -> hibernate
  typedef enum logic [2:0] {
    PMCD_RUN    = 3'b000,
    PMCD_SLEEP  = 3'b001,
    PMCD_DEEP   = 3'b011,
    PMCD_HIBER  = 3'b010,
    PMCD_RSTSEQ = 3'b110
  } pmcd_mode_t;

  // wake sources, synchronised as one vector
  typedef struct packed {
    logic rtc;
    logic eth;
    logic can;
    logic ext;
    logic rst;
  } pmcd_wake_t;

  // clock and power outputs
  typedef struct packed {
    logic       core_tick;
    logic       sys_tick;
    logic       sdram_tick;
    logic       buf_clk_en;
    logic       sdram_cke;
    logic       core_supply_on;
    logic       pins_hiz;
    logic       boot_reset;
    logic       pll_bypass;
    logic       pll_locked;
    logic [5:0] pll_msel;
    logic       pll_df;
    logic [3:0] vlev;
  } pmcd_clk_out_t;

endpackage : pmcd_pkg

// file: logic/pmcd_ctrl.sv
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`include "pmcd_defines.svh"
// Notes on behaviour
// - deep sleep stops core and system clocks
// - deep sleep exits only on reset or rtc
// - rtc wake from deep sleep enters active
// - reset in deep sleep enters full-on
// - regulator field zero enters hibernate
// - hibernate puts external pins high impedance
// - ethernet or can wake restarts regulator
// - reset, or rtc wake from hibernate, launches boot reset
// - only regulator register survives hibernate
// - cke hold bit keeps sdram in self-refresh
// - voltage code programmable, 50 mV steps
// - buffered clock on by default, disableable
// - multiplier resets to ten, range half..64
// - divider write changes clocks while running
// - sdram clock at system rate, gateable
// - system divider is binary value 1..15
// - system divider change needs no relock
// - core divider codes give 1,2,4,8
// - active mode bypasses pll, input rate
// - sleep wake picks mode from bypass bit
module pmcd_ctrl (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  // register port
  input  wire logic [7:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output      logic [31:0]           reg_rdata,
  // wake sources, asynchronous
  input  wire pmcd_pkg::pmcd_wake_t  wake_in,
  // clock and power outputs
  output      pmcd_pkg::pmcd_clk_out_t clk_out,
  output      pmcd_pkg::pmcd_mode_t  mode
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    pmcd_pkg::pmcd_wake_t    s1;
    pmcd_pkg::pmcd_wake_t    s2;
    pmcd_pkg::pmcd_mode_t    mode;
    logic [1:0]              reg_sw;
    logic [3:0]              vlev;
    logic                    cke_hold;
    logic                    cbuf_en;
    logic                    pll_df;
    logic [5:0]              msel;
    logic [5:0]              msel_act;
    logic                    df_act;
    logic                    bypass;
    logic [7:0]              lock_cnt;
    logic [3:0]              ssel;
    logic [1:0]              csel;
    logic [3:0]              ssel_act;
    logic [1:0]              csel_act;
    logic [3:0]              scnt;
    logic [2:0]              ccnt;
    logic                    sdr_clk_en;
    logic                    amem_clk_en;
    logic [7:0]              rst_cnt;
    logic [31:0]             rdata;
    pmcd_pkg::pmcd_clk_out_t out;
  } pmcd_state_t;

  pmcd_state_t st_r;
  pmcd_state_t st_nxt;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  function automatic logic [2:0] cdiv_last(input logic [1:0] cs);
    cdiv_last = 3'((4'h1 << cs) - 4'h1);
  endfunction : cdiv_last

  function automatic pmcd_state_t soft_reset(input pmcd_state_t s);
    soft_reset             = s;
    soft_reset.pll_df      = 1'b0;
    soft_reset.msel        = `PMCD_PLL_MSEL_RST;
    soft_reset.msel_act    = `PMCD_PLL_MSEL_RST;
    soft_reset.df_act      = 1'b0;
    soft_reset.bypass      = 1'b0;
    soft_reset.lock_cnt    = `PMCD_LOCK_CYC;
    soft_reset.ssel        = `PMCD_DIV_SSEL_RST;
    soft_reset.csel        = `PMCD_DIV_CSEL_RST;
    soft_reset.ssel_act    = `PMCD_DIV_SSEL_RST;
    soft_reset.csel_act    = `PMCD_DIV_CSEL_RST;
    soft_reset.scnt        = 4'h0;
    soft_reset.ccnt        = 3'h0;
    soft_reset.sdr_clk_en  = 1'b1;
    soft_reset.amem_clk_en = 1'b1;
    soft_reset.rst_cnt     = `PMCD_RST_CYC;
    soft_reset.mode        = pmcd_pkg::PMCD_RSTSEQ;
  endfunction : soft_reset

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic core_run;
    logic sys_run;
    logic s_wrap;
    logic c_wrap;
    core_run = 1'b0;
    sys_run  = 1'b0;
    s_wrap   = 1'b0;
    c_wrap   = 1'b0;
    st_nxt    = st_r;
    st_nxt.s1 = wake_in;
    st_nxt.s2 = st_r.s1;

    // register writes
    if (reg_wr) begin
      if (hit(reg_addr, `PMCD_OFF_REG_CTL)) begin
        st_nxt.reg_sw   = reg_wdata[`PMCD_REG_SW_LSB +: 2];
        st_nxt.vlev     = reg_wdata[`PMCD_REG_VLEV_LSB +: 4];
        st_nxt.cke_hold = reg_wdata[`PMCD_REG_CKE_BIT];
        st_nxt.cbuf_en  = reg_wdata[`PMCD_REG_CBUF_BIT];
      end
      if (hit(reg_addr, `PMCD_OFF_PLL_CONTROL_REG)) begin
        st_nxt.pll_df = reg_wdata[`PMCD_PLL_DF_BIT];
        st_nxt.msel   = reg_wdata[`PMCD_PLL_MSEL_LSB +: 6];
        st_nxt.bypass = reg_wdata[`PMCD_PLL_BYP_BIT];
      end
      if (hit(reg_addr, `PMCD_OFF_PLL_DIV)) begin
        if (reg_wdata[`PMCD_DIV_SSEL_LSB +: 4] != 4'h0) begin
          st_nxt.ssel = reg_wdata[`PMCD_DIV_SSEL_LSB +: 4];
        end
        st_nxt.csel = reg_wdata[`PMCD_DIV_CSEL_LSB +: 2];
      end
      if (hit(reg_addr, `PMCD_OFF_SDR_GCTL)) begin
        st_nxt.sdr_clk_en = reg_wdata[0];
      end
      if (hit(reg_addr, `PMCD_OFF_AMEM_GCTL)) begin
        st_nxt.amem_clk_en = reg_wdata[0];
      end
    end

    // multiplier takes effect through a relock, only outside bypass
    if (!st_r.bypass && (st_r.msel != st_r.msel_act || st_r.pll_df != st_r.df_act)) begin
      st_nxt.msel_act = st_r.msel;
      st_nxt.df_act   = st_r.pll_df;
      st_nxt.lock_cnt = `PMCD_LOCK_CYC;
    end else if (st_r.lock_cnt != 8'h00) begin
      st_nxt.lock_cnt = st_r.lock_cnt - 8'h01;
    end

    // mode control
    case (st_r.mode)
      pmcd_pkg::PMCD_RUN: begin
        if (st_r.s2.rst) begin
          st_nxt = soft_reset(st_nxt);
        end else if (reg_wr && hit(reg_addr, `PMCD_OFF_REG_CTL)
                     && reg_wdata[`PMCD_REG_SW_LSB +: 2] == `PMCD_REG_SW_OFF) begin
          st_nxt.mode = pmcd_pkg::PMCD_HIBER;
        end else if (reg_wr && hit(reg_addr, `PMCD_OFF_SLEEP_CMD)) begin
          if (reg_wdata[`PMCD_CMD_DEEP_BIT]) begin
            st_nxt.mode = pmcd_pkg::PMCD_DEEP;
          end else if (reg_wdata[`PMCD_CMD_SLEEP_BIT]) begin
            st_nxt.mode = pmcd_pkg::PMCD_SLEEP;
          end
        end
      end
      pmcd_pkg::PMCD_SLEEP: begin
        if (st_r.s2.rst) begin
          st_nxt = soft_reset(st_nxt);
        end else if (st_r.s2.rtc || st_r.s2.ext || st_r.s2.eth || st_r.s2.can) begin
          st_nxt.mode = pmcd_pkg::PMCD_RUN;
        end
      end
      pmcd_pkg::PMCD_DEEP: begin
        if (st_r.s2.rst) begin
          st_nxt = soft_reset(st_nxt);
        end else if (st_r.s2.rtc) begin
          st_nxt.mode   = pmcd_pkg::PMCD_RUN;
          st_nxt.bypass = 1'b1;
        end
        // other wake sources have no effect here
      end
      pmcd_pkg::PMCD_HIBER: begin
        if (st_r.s2.rtc || st_r.s2.rst || st_r.s2.eth || st_r.s2.can) begin
          st_nxt        = soft_reset(st_nxt);
          st_nxt.reg_sw = `PMCD_REG_SW_RST;
        end
      end
      pmcd_pkg::PMCD_RSTSEQ: begin
        if (st_r.rst_cnt != 8'h00) begin
          st_nxt.rst_cnt = st_r.rst_cnt - 8'h01;
        end else begin
          st_nxt.mode = pmcd_pkg::PMCD_RUN;
        end
      end
      default: begin
        st_nxt.mode = pmcd_pkg::PMCD_RUN;
      end
    endcase

    // divided clocks; core runs only in run, system also in sleep
    core_run = (st_r.mode == pmcd_pkg::PMCD_RUN);
    sys_run  = core_run || (st_r.mode == pmcd_pkg::PMCD_SLEEP);
    s_wrap   = st_r.bypass || (st_r.scnt >= st_r.ssel_act - 4'h1);
    c_wrap   = st_r.bypass || (st_r.ccnt >= cdiv_last(st_r.csel_act));
    if (sys_run) begin
      st_nxt.scnt = s_wrap ? 4'h0 : st_r.scnt + 4'h1;
      if (s_wrap) begin
        st_nxt.ssel_act = st_r.ssel;
      end
    end
    if (core_run) begin
      st_nxt.ccnt = c_wrap ? 3'h0 : st_r.ccnt + 3'h1;
      if (c_wrap) begin
        st_nxt.csel_act = st_r.csel;
      end
    end

    // registered outputs
    st_nxt.out.core_tick      = core_run && c_wrap;
    st_nxt.out.sys_tick       = sys_run && s_wrap;
    st_nxt.out.sdram_tick     = sys_run && s_wrap && st_r.sdr_clk_en
                                && st_r.amem_clk_en;
    st_nxt.out.core_supply_on = (st_r.mode != pmcd_pkg::PMCD_HIBER);
    st_nxt.out.pins_hiz       = (st_r.mode == pmcd_pkg::PMCD_HIBER);
    st_nxt.out.buf_clk_en     = st_r.cbuf_en && (st_r.mode != pmcd_pkg::PMCD_HIBER);
    st_nxt.out.boot_reset     = (st_r.mode == pmcd_pkg::PMCD_RSTSEQ);
    st_nxt.out.sdram_cke      = !(st_r.cke_hold && (st_r.mode == pmcd_pkg::PMCD_RSTSEQ
                                || st_r.mode == pmcd_pkg::PMCD_HIBER));
    st_nxt.out.pll_bypass     = st_r.bypass;
    st_nxt.out.pll_locked     = (st_r.lock_cnt == 8'h00);
    st_nxt.out.pll_msel       = st_r.msel_act;
    st_nxt.out.pll_df         = st_r.df_act;
    st_nxt.out.vlev           = st_r.vlev;

    // read data, one cycle after the strobe
    st_nxt.rdata = 32'h0000_0000;
    if (reg_rd) begin
      if (hit(reg_addr, `PMCD_OFF_REG_CTL)) begin
        st_nxt.rdata[`PMCD_REG_SW_LSB +: 2]   = st_r.reg_sw;
        st_nxt.rdata[`PMCD_REG_VLEV_LSB +: 4] = st_r.vlev;
        st_nxt.rdata[`PMCD_REG_CKE_BIT]       = st_r.cke_hold;
        st_nxt.rdata[`PMCD_REG_CBUF_BIT]      = st_r.cbuf_en;
      end
      if (hit(reg_addr, `PMCD_OFF_PLL_CONTROL_REG)) begin
        st_nxt.rdata[`PMCD_PLL_DF_BIT]        = st_r.pll_df;
        st_nxt.rdata[`PMCD_PLL_MSEL_LSB +: 6] = st_r.msel;
        st_nxt.rdata[`PMCD_PLL_BYP_BIT]       = st_r.bypass;
      end
      if (hit(reg_addr, `PMCD_OFF_PLL_DIV)) begin
        st_nxt.rdata[`PMCD_DIV_SSEL_LSB +: 4] = st_r.ssel;
        st_nxt.rdata[`PMCD_DIV_CSEL_LSB +: 2] = st_r.csel;
      end
      if (hit(reg_addr, `PMCD_OFF_SDR_GCTL)) begin
        st_nxt.rdata[0] = st_r.sdr_clk_en;
      end
      if (hit(reg_addr, `PMCD_OFF_AMEM_GCTL)) begin
        st_nxt.rdata[0] = st_r.amem_clk_en;
      end
      if (hit(reg_addr, `PMCD_OFF_STATUS)) begin
        st_nxt.rdata[2:0] = st_r.mode;
        st_nxt.rdata[3]   = (st_r.lock_cnt == 8'h00);
      end
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_r                    <= '0;
      st_r.mode               <= pmcd_pkg::PMCD_RUN;
      st_r.reg_sw             <= `PMCD_REG_SW_RST;
      st_r.vlev               <= `PMCD_REG_VLEV_RST;
      st_r.cbuf_en            <= 1'b1;
      st_r.msel               <= `PMCD_PLL_MSEL_RST;
      st_r.msel_act           <= `PMCD_PLL_MSEL_RST;
      st_r.lock_cnt           <= `PMCD_LOCK_CYC;
      st_r.ssel               <= `PMCD_DIV_SSEL_RST;
      st_r.ssel_act           <= `PMCD_DIV_SSEL_RST;
      st_r.csel               <= `PMCD_DIV_CSEL_RST;
      st_r.csel_act           <= `PMCD_DIV_CSEL_RST;
      st_r.sdr_clk_en         <= 1'b1;
      st_r.amem_clk_en        <= 1'b1;
      st_r.out.core_supply_on <= 1'b1;
      st_r.out.sdram_cke      <= 1'b1;
      st_r.out.pll_msel       <= `PMCD_PLL_MSEL_RST;
      st_r.out.vlev           <= `PMCD_REG_VLEV_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign clk_out   = st_r.out;
  assign mode      = st_r.mode;

endmodule : pmcd_ctrl

// file: dv/pmcd_wake_src.sv
`timescale 1ns/10ps
// ********
// wake source model
// ********
module pmcd_wake_src (
  // clock
  input  wire logic                 ref_clk,
  // one-cycle request from the bench
  input  wire pmcd_pkg::pmcd_wake_t wake_req,
  // wake levels toward the block
  output      pmcd_pkg::pmcd_wake_t wake_in
);
  logic [4:0] d1_r;
  logic [4:0] d2_r;
  logic [4:0] d3_r;
  initial begin
    d1_r = 5'h00;
    d2_r = 5'h00;
    d3_r = 5'h00;
    wake_in = 5'h00;
  end
  // stretch each request to four cycles, enough for the synchroniser
  always @(posedge ref_clk) begin
    d1_r <= wake_req;
    d2_r <= d1_r;
    d3_r <= d2_r;
    wake_in <= wake_req | d1_r | d2_r | d3_r;
  end
endmodule : pmcd_wake_src

// file: dv/pmcd_ctrl_assertions.sv
`timescale 1ns/10ps
// ********
// port checker
// ********
module pmcd_ctrl_checker (
  // clock and reset
  input wire logic                    ref_clk,
  input wire logic                    rst_n,
  // register port
  input wire logic [7:0]              reg_addr,
  input wire logic [31:0]             reg_wdata,
  input wire logic                    reg_wr,
  input wire logic                    reg_rd,
  input wire logic [31:0]             reg_rdata,
  // wake and outputs
  input wire pmcd_pkg::pmcd_wake_t    wake_in,
  input wire pmcd_pkg::pmcd_clk_out_t clk_out,
  input wire pmcd_pkg::pmcd_mode_t    mode
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence deep2_s;
    (mode == pmcd_pkg::PMCD_DEEP) [*2];
  endsequence
  sequence deep_run_s;
    mode == pmcd_pkg::PMCD_DEEP ##1 mode == pmcd_pkg::PMCD_RUN;
  endsequence
  sequence rst_run_s;
    mode == pmcd_pkg::PMCD_RSTSEQ ##1 mode == pmcd_pkg::PMCD_RUN;
  endsequence
  deep_clk_stop_a: assert property (deep2_s |-> !clk_out.core_tick && !clk_out.sys_tick)
    else $error("ticks in deep sleep");
  deep_exit_only_a: assert property ($past(mode) == pmcd_pkg::PMCD_DEEP &&
    mode != pmcd_pkg::PMCD_DEEP |-> mode inside {pmcd_pkg::PMCD_RUN, pmcd_pkg::PMCD_RSTSEQ})
    else $error("bad deep sleep exit");
  rtc_to_active_a: assert property (deep_run_s |=> clk_out.pll_bypass)
    else $error("rtc wake not active mode");
  reset_full_on_a: assert property (rst_run_s |=> !clk_out.pll_bypass)
    else $error("reset exit not full-on");
  hiber_power_a: assert property ((mode == pmcd_pkg::PMCD_HIBER) [*2] |->
    clk_out.pins_hiz && !clk_out.core_supply_on && !clk_out.sys_tick)
    else $error("hibernate outputs wrong");
  sdram_gate_a: assert property (clk_out.sdram_tick |-> clk_out.sys_tick)
    else $error("sdram tick without sys tick");
  sys_period_a: assert property (clk_out.sys_tick && mode == pmcd_pkg::PMCD_RUN |->
    ##[1:15] (clk_out.sys_tick || mode != pmcd_pkg::PMCD_RUN || !clk_out.pll_locked))
    else $error("sys tick gap over 15");
  core_period_a: assert property (clk_out.core_tick && mode == pmcd_pkg::PMCD_RUN |->
    ##[1:8] (clk_out.core_tick || mode != pmcd_pkg::PMCD_RUN || !clk_out.pll_locked))
    else $error("core tick gap over 8");
  bypass_rate_a: assert property ((mode == pmcd_pkg::PMCD_RUN && clk_out.pll_bypass) [*8]
    |-> clk_out.core_tick && clk_out.sys_tick)
    else $error("bypass not input rate");
  buf_default_a: assert property ($rose(rst_n) |=> clk_out.buf_clk_en)
    else $error("buffered clock off after reset");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside read cycle");
endmodule : pmcd_ctrl_checker
bind pmcd_ctrl pmcd_ctrl_checker u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .wake_in(wake_in), .clk_out(clk_out), .mode(mode));

// file: dv/test_power_mode_clock_divider_ctrl.sv
`timescale 1ns/10ps
// ********
// testbench
// ********
module test_power_mode_clock_divider_ctrl;
  logic                    ref_clk;
  logic                    rst_n;
  logic [7:0]              reg_addr;
  logic [31:0]             reg_wdata;
  logic                    reg_wr;
  logic                    reg_rd;
  logic [31:0]             reg_rdata;
  pmcd_pkg::pmcd_wake_t    wake_in;
  pmcd_pkg::pmcd_wake_t    wake_req;
  pmcd_pkg::pmcd_clk_out_t clk_out;
  pmcd_pkg::pmcd_mode_t    mode;
  int                      mismatches;
  int                      checked;
  pmcd_ctrl dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wake_in(wake_in),
    .clk_out(clk_out), .mode(mode));
  pmcd_wake_src u_src (.ref_clk(ref_clk), .wake_req(wake_req), .wake_in(wake_in));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic report_and_stop;
    if (mismatches == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge ref_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #1;
    chk(what, exp, reg_rdata);
  endtask : rd
  task automatic wake(input logic [4:0] w);
    @(posedge ref_clk);
    wake_req <= w;
    @(posedge ref_clk);
    wake_req <= 5'h00;
  endtask : wake
  task automatic wait_mode(input pmcd_pkg::pmcd_mode_t m);
    int n;
    n = 0;
    while (mode !== m && n < 100) begin
      tick(1);
      n++;
    end
    chk("mode", 32'(m), 32'(mode));
  endtask : wait_mode
  // cycles between two ticks of the chosen clock
  task automatic gap(input bit core, input logic [31:0] exp);
    int n;
    n = 0;
    tick(40);
    while ((core ? clk_out.core_tick : clk_out.sys_tick) !== 1'h1 && n < 20) begin
      tick(1);
      n++;
    end
    n = 0;
    do begin
      tick(1);
      n++;
    end while ((core ? clk_out.core_tick : clk_out.sys_tick) !== 1'h1 && n < 20);
    chk("tick gap", exp, 32'(n));
  endtask : gap
  task automatic t_reset;
    tick(2);
    chk("msel", 32'h0000_000a, 32'(clk_out.pll_msel));
    chk("vlev", 32'h0000_000b, 32'(clk_out.vlev));
    chk("buf_en", 32'h0000_0001, 32'(clk_out.buf_clk_en));
    rd(8'h40, 32'h0000_0000, "unmapped");
  endtask : t_reset
  task automatic t_div;
    for (int c = 0; c < 4; c++) begin
      wr(8'h08, 32'h0000_0006 | (c << 4));
      gap(1'h1, 32'h0000_0001 << c);
    end
    gap(1'h0, 32'h0000_0006);
    wr(8'h08, 32'h0000_000f);
    gap(1'h0, 32'h0000_000f);
    wr(8'h08, 32'h0000_0001);
    gap(1'h0, 32'h0000_0001);
    wr(8'h08, 32'h0000_0000);
    gap(1'h0, 32'h0000_0001);
  endtask : t_div
  task automatic t_reg;
    wr(8'h00, 32'h0000_0073);
    tick(2);
    chk("vlev", 32'h0000_0007, 32'(clk_out.vlev));
    chk("buf_en", 32'h0000_0000, 32'(clk_out.buf_clk_en));
    rd(8'h00, 32'h0000_0073, "reg_ctl");
    wr(8'h00, 32'h0000_02b3);
  endtask : t_reg
  task automatic t_sdram;
    int n;
    for (int i = 0; i < 4; i++) begin
      wr(8'h10 + 8'(4 * (i / 2)), 32'(i % 2));
      tick(4);
      n = 0;
      repeat (20) begin
        tick(1);
        n += int'(clk_out.sdram_tick === 1'h1);
      end
      chk("sdram ticks", 32'(20 * (i % 2)), 32'(n));
    end
  endtask : t_sdram
  task automatic t_deep;
    wr(8'h0c, 32'h0000_0003);
    wait_mode(pmcd_pkg::PMCD_DEEP);
    wake(5'h08);
    wake(5'h04);
    wake(5'h02);
    tick(10);
    chk("mode", 32'(pmcd_pkg::PMCD_DEEP), 32'(mode));
    wake(5'h10);
    wait_mode(pmcd_pkg::PMCD_RUN);
    tick(1);
    chk("bypass", 32'h0000_0001, 32'(clk_out.pll_bypass));
    wr(8'h0c, 32'h0000_0002);
    wait_mode(pmcd_pkg::PMCD_DEEP);
    wake(5'h01);
    wait_mode(pmcd_pkg::PMCD_RSTSEQ);
    wait_mode(pmcd_pkg::PMCD_RUN);
    tick(1);
    chk("bypass", 32'h0000_0000, 32'(clk_out.pll_bypass));
  endtask : t_deep
  task automatic t_sleep;
    for (int i = 1; i >= 0; i--) begin
      wr(8'h04, 32'h0000_0014 | (i << 8));
      wr(8'h0c, 32'h0000_0001);
      wait_mode(pmcd_pkg::PMCD_SLEEP);
      wake(5'h02);
      wait_mode(pmcd_pkg::PMCD_RUN);
      tick(1);
      chk("bypass", 32'(i), 32'(clk_out.pll_bypass));
    end
    wr(8'h04, 32'h0000_0017);
    tick(3);
    chk("locked", 32'h0000_0000, 32'(clk_out.pll_locked));
    chk("msel", 32'h0000_000b, 32'(clk_out.pll_msel));
    chk("df", 32'h0000_0001, 32'(clk_out.pll_df));
    rd(8'h18, 32'h0000_0000, "status");
    tick(20);
    chk("locked", 32'h0000_0001, 32'(clk_out.pll_locked));
  endtask : t_sleep
  task automatic t_hiber(input logic [4:0] src);
    wr(8'h08, 32'h0000_0023);
    wr(8'h00, 32'h0000_0373);
    wr(8'h00, 32'h0000_0370);
    wait_mode(pmcd_pkg::PMCD_HIBER);
    tick(1);
    chk("hiz", 32'h0000_0001, 32'(clk_out.pins_hiz));
    chk("supply", 32'h0000_0000, 32'(clk_out.core_supply_on));
    chk("cke", 32'h0000_0000, 32'(clk_out.sdram_cke));
    wake(5'h02);
    tick(8);
    chk("mode", 32'(pmcd_pkg::PMCD_HIBER), 32'(mode));
    wake(src);
    wait_mode(pmcd_pkg::PMCD_RSTSEQ);
    tick(1);
    chk("boot", 32'h0000_0001, 32'(clk_out.boot_reset));
    wait_mode(pmcd_pkg::PMCD_RUN);
    rd(8'h00, 32'h0000_0373, "reg_ctl");
    rd(8'h08, 32'h0000_0005, "div");
  endtask : t_hiber
  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #200000;
    mismatches++;
    report_and_stop;
  end
  initial begin
    rst_n = 1'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    wake_req = 5'h00;
    mismatches = 0;
    checked = 0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'h1;
    t_reset;
    t_div;
    t_reg;
    t_sdram;
    t_deep;
    t_sleep;
    t_hiber(5'h08);
    t_hiber(5'h04);
    t_hiber(5'h10);
    report_and_stop;
  end
endmodule : test_power_mode_clock_divider_ctrl
